/* File: rtl/exec_pkg.sv */
package exec_pkg;
    localparam int byte_w = 8;
    localparam int nib_w = 4;
    localparam int sign_bit = 7;
    localparam int addr_w = 12;
    localparam int data_w = 32;
    localparam int skip_count_w = 16;
    localparam int run_bit = 0;

    // register byte addresses
    localparam logic [11:0] off_working = 12'h000;
    localparam logic [11:0] off_status = 12'h004;
    localparam logic [11:0] off_ctrl = 12'h008;
    localparam logic [11:0] off_skips = 12'h00c;

    localparam logic [7:0] working_reset = 8'h00;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic run_reset = 1'b1;
    localparam logic [7:0] zero_byte = 8'h00;

    typedef enum logic [3:0] {
        op_none,
        op_sub_acc,
        op_subtract_to_memory,
        op_sub_imm,
        op_swap,
        op_swap_to_working,
        op_skip_if_zero,
        op_skip_if_zero_load,
        op_skip_bit_zero
    } opcode_t;

    typedef struct packed {
        logic chained_zero_flag;
        logic signed_compare_flag;
        logic [1:0] spare;
        logic ov;
        logic z;
        logic half_carry_flag;
        logic c;
    } status_t;

    typedef struct packed {
        opcode_t op;
        logic [7:0] operand;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } issue_t;
endpackage

/* File: rtl/sub_flags.sv */
`timescale 1ns/1ns
`default_nettype none

module sub_flags
(
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    // result
    output logic [7:0] diff,
    output exec_pkg::status_t flags
);
    logic [7:0] d;
    logic lo_ok;

    always_comb
    begin
        d = a - b;
        lo_ok = a[exec_pkg::nib_w-1:0] >= b[exec_pkg::nib_w-1:0];
        diff = d;
        flags = '0;
        // not-borrow: set when the difference is zero or positive
        flags.c = a >= b;
        flags.half_carry_flag = lo_ok;
        flags.z = d == exec_pkg::zero_byte;
        // chained zero equals plain zero when no carry-in is chained
        flags.chained_zero_flag = d == exec_pkg::zero_byte;
        flags.ov = (a[exec_pkg::sign_bit] != b[exec_pkg::sign_bit])
            && (d[exec_pkg::sign_bit] != a[exec_pkg::sign_bit]);
        flags.signed_compare_flag = flags.ov ^ d[exec_pkg::sign_bit];
    end
endmodule

`default_nettype wire

/* File: rtl/subtract_swap_skip_exec.sv */
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - subtract-to-memory writes working minus byte to memory, working kept
// - carry is cleared on a negative difference, set otherwise
// - subtracts update six flags and keep the other status bits
// - subtract-immediate puts working minus constant into working register
// - in-place swap exchanges nibbles of the byte, writes it back, no flags
// - swap-to-working loads swapped byte into working, memory kept, no flags
// - byte skip-if-zero skips next instruction when byte is zero, no flags
// - a taken skip takes two cycles with a dummy slot inserted
// - skip-if-zero-load copies byte to working and skips when it is zero
// - bit test skips when the selected bit is zero, no flags
module subtract_swap_skip_exec
#(
    parameter int skip_count_w = exec_pkg::skip_count_w
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction issue from decode
    input wire logic issue_valid,
    input wire exec_pkg::issue_t issue,
    output logic issue_ready,
    // results
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    output logic [7:0] working_register,
    output exec_pkg::status_t status_flags,
    output logic skip_next
);
    typedef enum logic {st_issue, st_dummy} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] wreg;
        exec_pkg::status_t status;
        logic run;
        logic [skip_count_w-1:0] skips;
        logic mem_wr_en;
        logic [7:0] mem_wr_data;
        logic armed;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    state_t st;
    state_t next_st;

    logic fire;
    logic apb_wr;
    logic take;
    logic [7:0] sub_b;
    logic [7:0] diff;
    logic [7:0] swapped;
    exec_pkg::status_t sub_st;

    sub_flags u_sub
    (
        .a(st.wreg),
        .b(sub_b),
        .diff(diff),
        .flags(sub_st)
    );

    assign issue_ready = st.run && st.phase == st_issue;
    assign fire = ce && issue_valid && issue_ready;
    // answer one cycle after setup; ce low holds the bus in wait
    assign pready = ce && psel && penable && st.armed;
    assign apb_wr = pready && pwrite;

    assign prdata = st.prdata;
    assign pslverr = st.pslverr && pready;
    assign mem_wr_en = st.mem_wr_en;
    assign mem_wr_data = st.mem_wr_data;
    assign working_register = st.wreg;
    assign status_flags = st.status;
    assign skip_next = st.phase == st_dummy;

    always_comb
    begin
        sub_b = issue.operand;
        if (issue.op == exec_pkg::op_sub_imm)
        begin
            sub_b = issue.imm;
        end
        swapped = {issue.operand[exec_pkg::nib_w-1:0],
            issue.operand[exec_pkg::byte_w-1:exec_pkg::nib_w]};
    end

    always_comb
    begin
        next_st = st;
        next_st.mem_wr_en = 1'b0;
        take = 1'b0;
        if (st.phase == st_dummy)
        begin
            next_st.phase = st_issue;
        end

        // read data is sampled in the setup cycle
        next_st.armed = psel && !(penable && st.armed);
        if (psel && !st.armed)
        begin
            next_st.prdata = '0;
            next_st.pslverr = 1'b0;
            case (paddr)
                exec_pkg::off_working:
                begin
                    next_st.prdata = 32'(st.wreg);
                end
                exec_pkg::off_status:
                begin
                    next_st.prdata = 32'(st.status);
                end
                exec_pkg::off_ctrl:
                begin
                    next_st.prdata = 32'(st.run);
                end
                exec_pkg::off_skips:
                begin
                    next_st.prdata = 32'(st.skips);
                end
                default:
                begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        // software writes lose against an instruction in the same cycle
        if (apb_wr)
        begin
            case (paddr)
                exec_pkg::off_working:
                begin
                    next_st.wreg = pwdata[exec_pkg::byte_w-1:0];
                end
                exec_pkg::off_status:
                begin
                    next_st.status = pwdata[exec_pkg::byte_w-1:0];
                end
                exec_pkg::off_ctrl:
                begin
                    next_st.run = pwdata[exec_pkg::run_bit];
                end
                exec_pkg::off_skips:
                begin
                    next_st.skips = '0;
                end
                default:
                begin
                    next_st.run = st.run;
                end
            endcase
        end

        if (fire)
        begin
            case (issue.op)
                exec_pkg::op_sub_acc:
                begin
                    next_st.wreg = diff;
                    next_st.status = sub_st;
                    next_st.status.spare = st.status.spare;
                end
                exec_pkg::op_subtract_to_memory:
                begin
                    next_st.mem_wr_en = 1'b1;
                    next_st.mem_wr_data = diff;
                    next_st.status = sub_st;
                    next_st.status.spare = st.status.spare;
                end
                exec_pkg::op_sub_imm:
                begin
                    next_st.wreg = diff;
                    next_st.status = sub_st;
                    next_st.status.spare = st.status.spare;
                end
                exec_pkg::op_swap:
                begin
                    next_st.mem_wr_en = 1'b1;
                    next_st.mem_wr_data = swapped;
                end
                exec_pkg::op_swap_to_working:
                begin
                    next_st.wreg = swapped;
                end
                exec_pkg::op_skip_if_zero:
                begin
                    take = issue.operand == exec_pkg::zero_byte;
                end
                exec_pkg::op_skip_if_zero_load:
                begin
                    next_st.wreg = issue.operand;
                    take = issue.operand == exec_pkg::zero_byte;
                end
                exec_pkg::op_skip_bit_zero:
                begin
                    take = !issue.operand[issue.bit_sel];
                end
                default:
                begin
                    take = 1'b0;
                end
            endcase
            if (take)
            begin
                next_st.phase = st_dummy;
                next_st.skips = st.skips + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st.phase <= st_issue;
            st.wreg <= exec_pkg::working_reset;
            st.status <= exec_pkg::status_reset;
            st.run <= exec_pkg::run_reset;
            st.skips <= '0;
            st.mem_wr_en <= 1'b0;
            st.mem_wr_data <= exec_pkg::zero_byte;
            st.armed <= 1'b0;
            st.prdata <= '0;
            st.pslverr <= 1'b0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = !apb_wr;

    chk_subtract_to_memory_result: assert property (
        fire && quiet && issue.op == exec_pkg::op_subtract_to_memory
        |=> mem_wr_en
            && mem_wr_data == 8'($past(st.wreg) - $past(issue.operand))
            && working_register == $past(st.wreg))
        else $error("subtract to memory result wrong");

    chk_carry_borrow: assert property (
        fire && quiet && (issue.op == exec_pkg::op_sub_acc
            || issue.op == exec_pkg::op_sub_imm)
        |=> status_flags.c == ($past(st.wreg) >= $past(
            issue.op == exec_pkg::op_sub_imm ? issue.imm : issue.operand)))
        else $error("carry is not a not-borrow");

    chk_spare_kept: assert property (
        fire && quiet && issue.op == exec_pkg::op_subtract_to_memory
        |=> status_flags.spare == $past(st.status.spare)
            && status_flags.z == (mem_wr_data == exec_pkg::zero_byte))
        else $error("status bits outside subtract set changed");

    chk_imm_sub: assert property (
        fire && quiet && issue.op == exec_pkg::op_sub_imm
        |=> working_register == 8'($past(st.wreg) - $past(issue.imm)))
        else $error("immediate subtract wrong");

    chk_swap_mem: assert property (
        fire && quiet && issue.op == exec_pkg::op_swap
        |=> mem_wr_en && mem_wr_data[3:0] == $past(issue.operand[7:4])
            && mem_wr_data[7:4] == $past(issue.operand[3:0])
            && status_flags == $past(st.status))
        else $error("in-place swap wrong");

    chk_swap_work: assert property (
        fire && quiet && issue.op == exec_pkg::op_swap_to_working
        |=> !mem_wr_en
            && working_register[3:0] == $past(issue.operand[7:4])
            && working_register[7:4] == $past(issue.operand[3:0])
            && status_flags == $past(st.status))
        else $error("swap to working wrong");

    chk_byte_skip: assert property (
        fire && quiet && issue.op == exec_pkg::op_skip_if_zero
        |=> skip_next == ($past(issue.operand) == exec_pkg::zero_byte)
            && status_flags == $past(st.status))
        else $error("byte skip decision wrong");

    chk_dummy_slot: assert property (
        (skip_next && ce) |=> !skip_next ##0 issue_ready == st.run)
        else $error("dummy slot longer than one cycle");

    chk_skip_stall: assert property (
        fire && take |=> skip_next && !issue_ready)
        else $error("taken skip did not insert a dummy slot");

    chk_load_skip: assert property (
        fire && quiet && issue.op == exec_pkg::op_skip_if_zero_load
        |=> working_register == $past(issue.operand)
            && skip_next == (working_register == exec_pkg::zero_byte))
        else $error("skip with load wrong");

    chk_bit_skip: assert property (
        fire && quiet && issue.op == exec_pkg::op_skip_bit_zero
        |=> skip_next == !$past(issue.operand[issue.bit_sel])
            && status_flags == $past(st.status))
        else $error("bit test skip wrong");

    chk_ov_rule: assert property (
        fire && quiet && issue.op == exec_pkg::op_sub_acc
        |=> status_flags.ov == (($past(st.wreg[7])
            != $past(issue.operand[7]))
            && (working_register[7] != $past(st.wreg[7]))))
        else $error("overflow flag wrong");

    cov_subtract_to_memory: cover property (
        fire && issue.op == exec_pkg::op_subtract_to_memory);
    cov_skip_taken: cover property (fire && take ##1 skip_next);
    cov_apb_read: cover property (pready && !pwrite);
    cov_borrow: cover property (fire && issue.op == exec_pkg::op_sub_acc
        ##1 !status_flags.c);
endmodule

`default_nettype wire

/* File: test/decode_model.sv */
`timescale 1ns/1ns
`default_nettype none

module decode_model
(
    // clock
    input wire logic mclk,
    // issue handshake
    input wire logic issue_ready,
    output logic issue_valid,
    output exec_pkg::issue_t issue
);
    initial
    begin
        issue_valid = 1'b0;
        issue = '0;
    end

    // request is held until taken; afterwards the lines are scrambled so a
    // late sample sees garbage, not the last instruction
    task automatic send(input exec_pkg::issue_t ins, input int stall);
        logic rdy;
        // always launch on a rising edge, never part way through a cycle
        repeat (stall + 1) @(posedge mclk);
        issue_valid <= 1'b1;
        issue <= ins;
        rdy = 1'b0;
        while (!rdy)
        begin
            @(posedge mclk);
            rdy = issue_ready;
        end
        issue_valid <= 1'b0;
        issue <= exec_pkg::issue_t'(~ins);
    endtask
endmodule

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic issue_valid, issue_ready, mem_wr_en, skip_next;
    exec_pkg::issue_t issue;
    logic [7:0] mem_wr_data, working_register, m_w, m_st, m_mem;
    exec_pkg::status_t status_flags;
    int err_total, n_compared, m_skips;
    logic [15:0] corners [6] = '{16'h8001, 16'h0001, 16'h1001, 16'h5555,
        16'h7fff, 16'h0080};

    subtract_swap_skip_exec DUT
    (
        .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .issue_valid(issue_valid),
        .issue(issue), .issue_ready(issue_ready), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .working_register(working_register),
        .status_flags(status_flags), .skip_next(skip_next)
    );

    decode_model dec
    (
        .mclk(mclk), .issue_ready(issue_ready), .issue_valid(issue_valid),
        .issue(issue)
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // answer is taken at the edge where pready is high, sampled just before
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic xerr);
        logic ok;
        logic [31:0] rd;
        logic er;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        ok = 1'b0;
        while (!ok)
        begin
            @(posedge mclk);
            ok = pready;
            rd = prdata;
            er = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!wr)
            chk(rd, exp);
        chk({31'h0, er}, {31'h0, xerr});
    endtask

    task automatic set_w(input logic [7:0] v);
        apb(1'b1, exec_pkg::off_working, {24'h0, v}, 32'h0, 1'b0);
        m_w = v;
    endtask

    task automatic ex(input exec_pkg::opcode_t op, input logic [7:0] m,
                      input logic [7:0] imm, input logic [2:0] b);
        logic [7:0] s, d, x;
        logic wen, sk, ov, sub;
        x = (op == exec_pkg::op_sub_imm) ? imm : m;
        d = m_w - x;
        s = {m[3:0], m[7:4]};
        ov = (m_w[7] != x[7]) && (d[7] != m_w[7]);
        sub = op inside {exec_pkg::op_sub_acc, exec_pkg::op_sub_imm,
            exec_pkg::op_subtract_to_memory};
        wen = op inside {exec_pkg::op_subtract_to_memory, exec_pkg::op_swap};
        sk = (op == exec_pkg::op_skip_bit_zero) && !m[b];
        if (op inside {exec_pkg::op_skip_if_zero,
            exec_pkg::op_skip_if_zero_load})
            sk = (m == 8'h00);
        if (sub)
            m_st = {d == 8'h00, ov ^ d[7], m_st[5:4], ov, d == 8'h00,
                m_w[3:0] >= x[3:0], m_w >= x};
        if (wen)
            m_mem = (op == exec_pkg::op_swap) ? s : d;
        if (op == exec_pkg::op_sub_acc || op == exec_pkg::op_sub_imm)
            m_w = d;
        else if (op == exec_pkg::op_swap_to_working)
            m_w = s;
        else if (op == exec_pkg::op_skip_if_zero_load)
            m_w = m;
        m_skips += sk;
        dec.send('{op, m, imm, b}, int'(rnd() % 3));
        #1;
        chk(working_register, m_w);
        chk(status_flags, m_st);
        chk({mem_wr_en, mem_wr_data}, {wen, m_mem});
        chk({skip_next, issue_ready}, {sk, !sk});
        if (sk)
        begin
            @(posedge mclk);
            #1;
            chk({skip_next, issue_ready}, 2'b01);
        end
    endtask

    initial
    begin
        #800000;
        err_total++;
        end_sim();
    end

    initial
    begin
        logic [31:0] r;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        seed = 32'h00013933;
        err_total = 0;
        n_compared = 0;
        m_skips = 0;
        m_w = 8'h00;
        m_st = 8'h00;
        m_mem = 8'h00;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk({working_register, status_flags}, 16'h0000);
        chk({skip_next, mem_wr_en, issue_ready}, 3'b001);
        apb(1'b0, exec_pkg::off_ctrl, 32'h0, 32'h1, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h5a, 32'h0, 1'b1);
        // spare status bits set so that subtracts must keep them
        apb(1'b1, exec_pkg::off_status, 32'h30, 32'h0, 1'b0);
        m_st = 8'h30;
        foreach (corners[i])
            for (int k = 1; k <= 3; k++)
            begin
                set_w(corners[i][15:8]);
                ex(exec_pkg::opcode_t'(k), corners[i][7:0], corners[i][7:0],
                    3'h0);
                apb(1'b0, exec_pkg::off_status, 32'h0, {24'h0, m_st},
                    1'b0);
            end
        for (int k = 4; k <= 8; k++)
        begin
            ex(exec_pkg::opcode_t'(k), 8'h00, 8'h00, 3'h5);
            for (int j = 0; j < 8; j++)
            begin
                ex(exec_pkg::opcode_t'(k), 8'h01 << j, 8'h00, 3'(j));
                ex(exec_pkg::opcode_t'(k), ~(8'h01 << j), 8'h00, 3'(j));
            end
        end
        repeat (200)
        begin
            r = rnd();
            ex(exec_pkg::opcode_t'(r[27:24] % 4'h9), r[7:0], r[15:8],
                r[18:16]);
        end
        apb(1'b0, exec_pkg::off_skips, 32'h0, 32'(m_skips), 1'b0);
        apb(1'b1, exec_pkg::off_skips, 32'h0, 32'h0, 1'b0);
        apb(1'b0, exec_pkg::off_skips, 32'h0, 32'h0, 1'b0);
        apb(1'b1, exec_pkg::off_ctrl, 32'h0, 32'h0, 1'b0);
        #1;
        chk({31'h0, issue_ready}, 32'h0);
        apb(1'b1, exec_pkg::off_ctrl, 32'h1, 32'h0, 1'b0);
        // enable low must hold a pending read in wait and freeze state
        fork
            apb(1'b0, exec_pkg::off_working, 32'h0, {24'h0, m_w}, 1'b0);
            begin
                @(posedge mclk);
                ce <= 1'b0;
                repeat (4) @(posedge mclk);
                chk({31'h0, pready}, 32'h0);
                ce <= 1'b1;
            end
        join
        // second reset in mid-run
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        m_w = 8'h00;
        m_st = 8'h00;
        m_mem = 8'h00;
        #1;
        chk({working_register, status_flags}, 16'h0000);
        ex(exec_pkg::op_sub_acc, 8'h01, 8'h00, 3'h0);
        end_sim();
    end
endmodule

`default_nettype wire
